//--- bench/autocycle_asserts.sv
`timescale 1ns/1ps
module autocycle_asserts #(
  parameter bit FOUR_PIN = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // inputs
  input wire logic csN,
  input wire logic autonomousEnableBit,
  input wire logic convertStartPin,
  input wire logic conversionDone,
  input wire logic limitFlag,
  input wire logic alertEnable,
  // outputs
  input wire logic convMode,
  input wire logic convertStart,
  input wire logic busyFlag,
  input wire logic alertFlag,
  input wire logic sharedFlagPinZeroOut,
  input wire logic sharedFlagPinZeroOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ****
  // conversion events
  // ****
  // limit level held until the alert update has surely landed
  sequence startHigh;
    (convertStart && limitFlag) ##1 limitFlag [*5];
  endsequence
  sequence startLow;
    (convertStart && !limitFlag) ##1 (!limitFlag) [*5];
  endsequence
  chk_alert_sets: assert property (startHigh |-> alertFlag)
    else $error("alert not set after start");
  chk_alert_clears: assert property (startLow |-> !alertFlag)
    else $error("alert not cleared after start");
  chk_busy_rise: assert property (convertStart |=> busyFlag)
    else $error("busy not raised by start");
  chk_busy_fall: assert property (conversionDone && !convertStart |=> !busyFlag)
    else $error("busy not dropped at done");
  // busy low through the idle window that ends at a timed start
  property idleBeforeStart;
    convertStart && autonomousEnableBit |->
      !busyFlag && !$past(busyFlag) && !$past(busyFlag, 2) && !$past(busyFlag, 3);
  endproperty
  chk_idle_busy: assert property (idleBeforeStart)
    else $error("busy high inside idle window");
  chk_quiet_external: assert property ((!autonomousEnableBit && !convertStartPin) [*3] |-> !convertStart)
    else $error("start without any cause");
  // ****
  // mode change and pin zero alert
  // ****
  chk_switch_at_cs: assert property ($fell(convMode) |-> $past(csN) && !$past(csN, 2))
    else $error("mode left before chip select rose");
  chk_mode_sticky: assert property (!convMode |=> !convMode)
    else $error("configuration mode left");
  chk_cfg_no_start: assert property (!convMode |-> !convertStart)
    else $error("start in configuration mode");
  chk_pin_alert: assert property (FOUR_PIN && alertEnable |-> sharedFlagPinZeroOe && sharedFlagPinZeroOut == alertFlag)
    else $error("pin zero not showing alert");
endmodule : autocycle_asserts

//--- bench/autocycle_convert_and_pin_mux_tb.sv
`timescale 1ns/1ps
module autocycle_convert_and_pin_mux_tb;
  logic clk, nrst, csN, sclk, serialIn, autonomousEnableBit, convertStartPin;
  logic conversionDone, limitFlag, alertEnable, busyEnable, convMode, convertStart;
  logic busyFlag, alertFlag, sharedFlagPinZeroOut, sharedFlagPinZeroOe;
  logic auxPinOneOut, auxPinOneOe, auxPinTwoOut, auxPinTwoOe, auxPinThreeOut, auxPinThreeOe;
  logic [2:0] autonomousPeriodField;
  logic [3:1] laneData;
  logic [3:0] gpoEnable, gpoValue;
  logic singlePinOut, singlePinOe;
  logic [2:0] singleAuxOe;
  autocycle_pkg::laneMode_t laneMode;
  int fails, checks, pulseCnt, doneCnt, n, start;
  int periodUs[8] = '{10, 20, 40, 80, 100, 200, 400, 800};
  autocycle_convert_and_pin_mux u_autocycle_convert_and_pin_mux (
    .clk, .nrst, .csN, .sclk, .serialIn, .autonomousEnableBit, .autonomousPeriodField,
    .laneMode, .alertEnable, .busyEnable, .gpoEnable, .gpoValue, .convertStartPin,
    .conversionDone, .limitFlag, .laneData, .convMode, .convertStart, .busyFlag, .alertFlag,
    .sharedFlagPinZeroOut, .sharedFlagPinZeroOe, .auxPinOneOut, .auxPinOneOe,
    .auxPinTwoOut, .auxPinTwoOe, .auxPinThreeOut, .auxPinThreeOe
  );
  // single-pin variant, watched on its shared pin and on its three aux pin enables
  autocycle_convert_and_pin_mux #(.FOUR_PIN(1'b0)) u_autocycle_convert_and_pin_mux_single (
    .clk, .nrst, .csN, .sclk, .serialIn, .autonomousEnableBit, .autonomousPeriodField,
    .laneMode, .alertEnable, .busyEnable, .gpoEnable, .gpoValue, .convertStartPin,
    .conversionDone, .limitFlag, .laneData, .convMode(), .convertStart(), .busyFlag(),
    .alertFlag(), .sharedFlagPinZeroOut(singlePinOut), .sharedFlagPinZeroOe(singlePinOe),
    .auxPinOneOut(), .auxPinOneOe(singleAuxOe[0]), .auxPinTwoOut(),
    .auxPinTwoOe(singleAuxOe[1]), .auxPinThreeOut(), .auxPinThreeOe(singleAuxOe[2])
  );
  host_spi_model u_host_spi_model (.clk, .csN, .sclk, .serialIn);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // core stand-in: done 20 cycles after each start
  // starts are counted mid-cycle, where the combinational pulse has settled
  always @(negedge clk) begin
    if (convertStart === 1'b1) pulseCnt++;
    doneCnt = (convertStart === 1'b1) ? 20 : (doneCnt > 0 ? doneCnt - 1 : 0);
  end
  always @(posedge clk) begin
    #1 conversionDone = (doneCnt == 1);
  end
  // ****
  // tasks
  // ****
  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  task automatic checkBits(string what, logic [7:0] e, logic [7:0] got);
    checks++;
    if (got !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask : checkBits
  task automatic checkCount(string what, int e, int got);
    checks++;
    if (got != e) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, e, got);
    end
  endtask : checkCount
  task automatic cycles(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cycles
  task automatic resetDut();
    nrst = 1'b0;
    cycles(6);
    nrst = 1'b1;
    cycles(3);
  endtask : resetDut
  // next code goes in mid-period so a truncation would show
  task automatic waitPulse(logic [2:0] nextCode);
    start = pulseCnt;
    n = 0;
    while (pulseCnt == start) begin
      cycles(1);
      n++;
      if (n == 10) begin
        autonomousPeriodField = nextCode;
        limitFlag = nextCode[0];
      end
      if (n > 40000) begin
        fails++;
        complete_run();
      end
    end
  endtask : waitPulse
  task automatic waitIdle();
    for (int i = 0; busyFlag !== 1'b0; i++) begin
      cycles(1);
      if (i > 100) begin
        fails++;
        complete_run();
      end
    end
  endtask : waitIdle
  task automatic pinCase(autocycle_pkg::laneMode_t m, logic a, logic b, logic [3:0] g,
                         logic [7:0] e, logic [1:0] es);
    logic [3:0] oe, po;
    logic [7:0] sp;
    laneMode = m;
    alertEnable = a;
    busyEnable = b;
    gpoEnable = g;
    cycles(1);
    oe = {auxPinThreeOe, auxPinTwoOe, auxPinOneOe, sharedFlagPinZeroOe};
    po = {auxPinThreeOut, auxPinTwoOut, auxPinOneOut, sharedFlagPinZeroOut};
    checkBits("pins", e, {oe, oe & po});
    sp = {3'h0, singleAuxOe, singlePinOe, singlePinOe & singlePinOut};
    checkBits("single pin", {6'h0, es}, sp);
  endtask : pinCase
  // ****
  // main sequence
  // ****
  initial begin
    nrst = 1'b0;
    autonomousEnableBit = 1'b0;
    autonomousPeriodField = 3'h0;
    convertStartPin = 1'b0;
    conversionDone = 1'b0;
    limitFlag = 1'b0;
    laneData = 3'h5;
    gpoValue = 4'h5;
    laneMode = autocycle_pkg::LANE_SINGLE;
    alertEnable = 1'b0;
    busyEnable = 1'b0;
    gpoEnable = 4'h0;
    resetDut();
    u_host_spi_model.hold(1'b0);
    pinCase(autocycle_pkg::LANE_SINGLE, 1'b0, 1'b0, 4'h0, 8'h00, 2'h0);
    pinCase(autocycle_pkg::LANE_SINGLE, 1'b0, 1'b0, 4'hF, 8'hF5, 2'h3);
    pinCase(autocycle_pkg::LANE_QUAD, 1'b1, 1'b1, 4'hF, 8'hFA, 2'h2);
    pinCase(autocycle_pkg::LANE_DUAL, 1'b1, 1'b0, 4'hF, 8'hF2, 2'h3);
    pinCase(autocycle_pkg::LANE_SINGLE, 1'b0, 1'b1, 4'h8, 8'h90, 2'h2);
    pinCase(autocycle_pkg::LANE_SINGLE, 1'b1, 1'b0, 4'h0, 8'h50, 2'h2);
    u_host_spi_model.hold(1'b1);
    pinCase(autocycle_pkg::LANE_QUAD, 1'b1, 1'b1, 4'hF, 8'hF0, 2'h2);
    autonomousEnableBit = 1'b1;
    waitPulse(3'h0);
    checkCount("first start", 1, int'(n >= 399 && n <= 402));
    for (int c = 0; c < 8; c++) begin
      waitPulse(3'((c + 1) % 8));
      checkCount("period", periodUs[c] * autocycle_pkg::CLK_MHZ, n);
    end
    waitPulse(3'h0);
    waitIdle();
    u_host_spi_model.frame(5'h15);
    cycles(3);
    checkBits("mode", 8'h01, {7'h0, convMode});
    waitPulse(3'h0);
    waitIdle();
    u_host_spi_model.frame(autocycle_pkg::REG_CONFIG_CMD);
    checkBits("mode early", 8'h01, {7'h0, convMode});
    cycles(3);
    checkBits("mode", 8'h00, {7'h0, convMode});
    start = pulseCnt;
    cycles(1000);
    checkCount("pulses", 0, pulseCnt - start);
    autonomousEnableBit = 1'b0;
    resetDut();
    start = pulseCnt;
    cycles(500);
    checkCount("pulses", 0, pulseCnt - start);
    convertStartPin = 1'b1;
    cycles(2);
    convertStartPin = 1'b0;
    cycles(4);
    checkCount("pulses", 1, pulseCnt - start);
    complete_run();
  end
endmodule : autocycle_convert_and_pin_mux_tb
bind autocycle_convert_and_pin_mux autocycle_asserts #(.FOUR_PIN(FOUR_PIN)) u_autocycle_asserts (
  .clk, .nrst, .csN, .autonomousEnableBit, .convertStartPin, .conversionDone, .limitFlag,
  .alertEnable, .convMode, .convertStart, .busyFlag, .alertFlag, .sharedFlagPinZeroOut,
  .sharedFlagPinZeroOe
);

//--- bench/host_spi_model.sv
`timescale 1ns/1ps
module host_spi_model #(
  parameter int ENTRY_CYC = 8
) (
  // clock
  input wire logic clk,
  // serial lines
  output logic csN,
  output logic sclk,
  output logic serialIn
);
  // sclk parked low outside frames
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    serialIn = 1'b1;
  end
  // frame held open with no clock, for lane output checks
  task automatic hold(logic lvl);
    csN = lvl;
  endtask : hold
  task automatic frame(logic [4:0] cmd);
    @(posedge clk);
    #1 csN = 1'b0;
    for (int i = 4; i >= 0; i--) begin
      serialIn = cmd[i];
      repeat (2) @(posedge clk);
      #1 sclk = 1'b1;
      repeat (2) @(posedge clk);
      #1 sclk = 1'b0;
    end
    repeat (ENTRY_CYC) @(posedge clk);
    #1 csN = 1'b1;
    // released line must not keep its last bit
    serialIn = ~serialIn;
  endtask : frame
endmodule : host_spi_model

//--- core/autocycle_convert_and_pin_mux.sv
`timescale 1ns/1ps
module autocycle_convert_and_pin_mux #(
  parameter bit FOUR_PIN = 1'b1,
  parameter int ALERT_DELAY_CYC = 4,
  parameter int IDLE_BUSY_CYC = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial port, sampled synchronously
  input wire logic csN,
  input wire logic sclk,
  input wire logic serialIn,
  // configuration
  input wire logic autonomousEnableBit,
  input wire logic [2:0] autonomousPeriodField,
  input wire autocycle_pkg::laneMode_t laneMode,
  input wire logic alertEnable,
  input wire logic busyEnable,
  input wire logic [3:0] gpoEnable,
  input wire logic [3:0] gpoValue,
  // conversion core
  input wire logic convertStartPin,
  input wire logic conversionDone,
  input wire logic limitFlag,
  input wire logic [3:1] laneData,
  // status
  output logic convMode,
  output logic convertStart,
  output logic busyFlag,
  output logic alertFlag,
  // pins
  output logic sharedFlagPinZeroOut,
  output logic sharedFlagPinZeroOe,
  output logic auxPinOneOut,
  output logic auxPinOneOe,
  output logic auxPinTwoOut,
  output logic auxPinTwoOe,
  output logic auxPinThreeOut,
  output logic auxPinThreeOe
);

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rstSync_q;
  logic rstN;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];

  // ****************************************
  // serial command capture
  // ****************************************
  logic sclk_q, csN_q, cnvPin_q;
  logic [4:0] shift_q, shift_d;
  logic [2:0] bitCnt_q, bitCnt_d;
  logic armed_q, armed_d;
  logic pending_q, pending_d;
  logic convMode_q, convMode_d;
  logic sclkRise, csRise;

  assign sclkRise = sclk && !sclk_q;
  assign csRise = csN && !csN_q;

  always_comb begin
    shift_d = shift_q;
    bitCnt_d = bitCnt_q;
    armed_d = armed_q;
    pending_d = pending_q;
    convMode_d = convMode_q;
    if (!csN && sclkRise && convMode_q && armed_q) begin
      shift_d = {shift_q[3:0], serialIn};
      bitCnt_d = 3'(bitCnt_q + 3'h1);
      if (bitCnt_q == 3'(autocycle_pkg::CMD_BITS - 1)) begin
        armed_d = 1'b0;
        if ({shift_q[3:0], serialIn} == autocycle_pkg::REG_CONFIG_CMD) begin
          pending_d = 1'b1;
        end
      end
    end
    if (csRise) begin
      armed_d = 1'b0;
      if (pending_q) begin
        pending_d = 1'b0;
        convMode_d = 1'b0;
      end
    end
    // a new conversion re-arms the five-bit window; placed last so a start
    // that meets a fifth bit or a chip select rise still opens its window
    if (convertStart) begin
      armed_d = 1'b1;
      bitCnt_d = 3'h0;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sclk_q <= 1'b0;
      csN_q <= 1'b1;
      cnvPin_q <= 1'b0;
      shift_q <= 5'h00;
      bitCnt_q <= 3'h0;
      armed_q <= 1'b0;
      pending_q <= 1'b0;
      convMode_q <= autocycle_pkg::RESET_CONV_MODE;
    end else begin
      sclk_q <= sclk;
      csN_q <= csN;
      cnvPin_q <= convertStartPin;
      shift_q <= shift_d;
      bitCnt_q <= bitCnt_d;
      armed_q <= armed_d;
      pending_q <= pending_d;
      convMode_q <= convMode_d;
    end
  end
  assign convMode = convMode_q;

  // ****************************************
  // autonomous convert-start timer
  // ****************************************
  function automatic logic [15:0] periodCycles(input logic [2:0] code);
    logic [15:0] c;
    c = 16'(autocycle_pkg::PERIOD_CYC_0);
    unique case (code)
      3'h0: c = 16'(autocycle_pkg::PERIOD_CYC_0);
      3'h1: c = 16'(autocycle_pkg::PERIOD_CYC_1);
      3'h2: c = 16'(autocycle_pkg::PERIOD_CYC_2);
      3'h3: c = 16'(autocycle_pkg::PERIOD_CYC_3);
      3'h4: c = 16'(autocycle_pkg::PERIOD_CYC_4);
      3'h5: c = 16'(autocycle_pkg::PERIOD_CYC_5);
      3'h6: c = 16'(autocycle_pkg::PERIOD_CYC_6);
      3'h7: c = 16'(autocycle_pkg::PERIOD_CYC_7);
    endcase
    return c;
  endfunction : periodCycles

  logic [15:0] tmr_q, tmr_d;
  logic running_q, running_d;
  logic autoPulse, extPulse;

  assign running_d = convMode_q && autonomousEnableBit;
  assign autoPulse = running_q && running_d && (tmr_q == 16'h0001);
  // external edges only when autonomous is off
  assign extPulse = !autonomousEnableBit && convMode_q && convertStartPin && !cnvPin_q;
  assign convertStart = autoPulse || extPulse;

  always_comb begin
    tmr_d = tmr_q;
    if (!running_d) begin
      tmr_d = 16'h0000;
    end else if (!running_q || autoPulse) begin
      // period sampled at period start only
      tmr_d = periodCycles(autonomousPeriodField);
    end else begin
      tmr_d = 16'(tmr_q - 16'h0001);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tmr_q <= 16'h0000;
      running_q <= 1'b0;
    end else begin
      tmr_q <= tmr_d;
      running_q <= running_d;
    end
  end

  // ****************************************
  // busy and alert indicators
  // ****************************************
  logic busy_q, busy_d;
  logic alert_q, alert_d;
  logic [7:0] alertCnt_q, alertCnt_d;
  logic idleWindow;

  // idle gap before next start
  // a slow core could hold busy across the next start; forcing it low here
  // keeps the host's busy edge trustworthy, at the cost of an early drop
  assign idleWindow = running_q && (tmr_q <= 16'(IDLE_BUSY_CYC + 1));

  always_comb begin
    busy_d = busy_q;
    // busy high at start, low at done
    if (convertStart) begin
      busy_d = 1'b1;
    end else if (conversionDone) begin
      busy_d = 1'b0;
    end else if (idleWindow) begin
      busy_d = 1'b0;
    end
    alert_d = alert_q;
    alertCnt_d = alertCnt_q;
    // alert updated fixed delay after start
    if (convertStart) begin
      alertCnt_d = 8'(ALERT_DELAY_CYC);
    end else if (alertCnt_q != 8'h00) begin
      alertCnt_d = 8'(alertCnt_q - 8'h01);
      if (alertCnt_q == 8'h01) begin
        alert_d = limitFlag;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      busy_q <= 1'b0;
      alert_q <= 1'b0;
      alertCnt_q <= 8'h00;
    end else begin
      busy_q <= busy_d;
      alert_q <= alert_d;
      alertCnt_q <= alertCnt_d;
    end
  end
  // indicators are registered, so the pins never glitch on them
  assign busyFlag = busy_q;
  assign alertFlag = alert_q;

  // ****************************************
  // pin priority
  // ****************************************
  logic dual, quad, lanesOn;
  assign quad = (laneMode == autocycle_pkg::LANE_QUAD);
  assign dual = (laneMode == autocycle_pkg::LANE_DUAL);
  // lanes tristate while chip select high
  assign lanesOn = !csN;

  logic [2:0] p0En, p0Val;
  logic [1:0] p2En, p2Val, p3En, p3Val;
  logic p1En;
  // pin zero order depends on variant
  assign p0En = FOUR_PIN ? {1'b0, busyEnable, alertEnable}
                         : {busyEnable, alertEnable, dual && lanesOn};
  assign p0Val = FOUR_PIN ? {1'b0, busy_q, alert_q} : {busy_q, alert_q, laneData[1]};
  assign p1En = FOUR_PIN && (dual || quad) && lanesOn;
  assign p2En = FOUR_PIN ? {alertEnable, quad && lanesOn} : 2'b00;
  assign p2Val = {alert_q, laneData[2]};
  assign p3En = FOUR_PIN ? {busyEnable, quad && lanesOn} : 2'b00;
  assign p3Val = {busy_q, laneData[3]};

  pin_priority_mux #(.N(3)) pinZero (
    .funcEn(p0En), .funcVal(p0Val), .gpoEn(gpoEnable[0]), .gpoVal(gpoValue[0]),
    .pinOut(sharedFlagPinZeroOut), .pinOe(sharedFlagPinZeroOe));
  pin_priority_mux #(.N(1)) pinOne (
    .funcEn(p1En), .funcVal(laneData[1]),
    .gpoEn(FOUR_PIN && gpoEnable[1]), .gpoVal(gpoValue[1]),
    .pinOut(auxPinOneOut), .pinOe(auxPinOneOe));
  pin_priority_mux #(.N(2)) pinTwo (
    .funcEn(p2En), .funcVal(p2Val),
    .gpoEn(FOUR_PIN && gpoEnable[2]), .gpoVal(gpoValue[2]),
    .pinOut(auxPinTwoOut), .pinOe(auxPinTwoOe));
  pin_priority_mux #(.N(2)) pinThree (
    .funcEn(p3En), .funcVal(p3Val),
    .gpoEn(FOUR_PIN && gpoEnable[3]), .gpoVal(gpoValue[3]),
    .pinOut(auxPinThreeOut), .pinOe(auxPinThreeOe));

endmodule : autocycle_convert_and_pin_mux

//--- core/autocycle_pkg.sv
package autocycle_pkg;

  // ****************************************
  // mode-change command
  // ****************************************
  localparam logic [4:0] REG_CONFIG_CMD = 5'h0A;
  localparam int CMD_BITS = 5;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 40;
  // period codes 0..7 in microseconds
  localparam int PERIOD_US_0 = 10;
  localparam int PERIOD_US_1 = 20;
  localparam int PERIOD_US_2 = 40;
  localparam int PERIOD_US_3 = 80;
  localparam int PERIOD_US_4 = 100;
  localparam int PERIOD_US_5 = 200;
  localparam int PERIOD_US_6 = 400;
  localparam int PERIOD_US_7 = 800;
  localparam int PERIOD_CYC_0 = PERIOD_US_0 * CLK_MHZ;
  localparam int PERIOD_CYC_1 = PERIOD_US_1 * CLK_MHZ;
  localparam int PERIOD_CYC_2 = PERIOD_US_2 * CLK_MHZ;
  localparam int PERIOD_CYC_3 = PERIOD_US_3 * CLK_MHZ;
  localparam int PERIOD_CYC_4 = PERIOD_US_4 * CLK_MHZ;
  localparam int PERIOD_CYC_5 = PERIOD_US_5 * CLK_MHZ;
  localparam int PERIOD_CYC_6 = PERIOD_US_6 * CLK_MHZ;
  localparam int PERIOD_CYC_7 = PERIOD_US_7 * CLK_MHZ;
  localparam int PERIOD_W = 16;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic RESET_CONV_MODE = 1'b1;

  // ****************************************
  // lane modes
  // ****************************************
  typedef enum logic [1:0] {LANE_SINGLE, LANE_DUAL, LANE_QUAD} laneMode_t;

endpackage : autocycle_pkg

//--- core/pin_priority_mux.sv
`timescale 1ns/1ps
// one shared pin: first enabled function in priority order wins
module pin_priority_mux #(
  parameter int N = 4
) (
  // function requests, index 0 highest priority
  input wire logic [N-1:0] funcEn,
  input wire logic [N-1:0] funcVal,
  // gpio fallback
  input wire logic gpoEn,
  input wire logic gpoVal,
  // pin drive
  output logic pinOut,
  output logic pinOe
);

  always_comb begin
    pinOut = gpoVal;
    pinOe = gpoEn;
    for (int i = N - 1; i >= 0; i--) begin
      if (funcEn[i]) begin
        pinOut = funcVal[i];
        pinOe = 1'b1;
      end
    end
  end

endmodule : pin_priority_mux
